/* hb_gate_ctrl.sv */
// H-bridge gate control with dead time, fault diagnosis and register slave
// How it works
// - Mode select high: enable routes inputs a,b,c,d to high a,b, low a,b.
// - Dead time from software setting separates turn-off and opposite turn-on.
// - No fault: diagnosis flag a high, flag b low.
// - Battery or logic-supply undervoltage: both diagnosis flags low.
// - Overtemperature: both diagnosis flags high.
// - Short circuit: diagnosis flag a low, flag b high.
// - Priority: undervoltage, then overtemperature, then short circuit.
// - Battery undervoltage sets at detect level, clears only at release level.
// - Fault select low: battery undervoltage forces all gates low.
// - Fault select high: gates keep normal control in battery undervoltage.
// - Logic supply low resets logic, gates low, charge pump stopped.
// - Logic supply low indication is filtered against chattering.
// - Overtemperature sets above upper threshold, clears below lower one.
// - Overtemperature changes only diagnosis flags and its status bit, never the gates.
// - Short flagged with fault select low forces gates low; high keeps them.
// - Qualified short must persist one cycle longer than the filter setting before it is flagged.
// - Each short comparator is qualified by the opposite gate of its half-bridge.
// - Mode select low: rotation, brake and PWM inputs drive the gates.
`timescale 1ns/1ps
`default_nettype none
`include "hb_params.svh"

module hb_gate_ctrl (
    input wire logic core_clk,
    input wire logic rst_n,
    input wire logic [`HB_AW-1:0] avs_address,
    input wire logic avs_read,
    input wire logic avs_write,
    input wire logic [`HB_DW-1:0] avs_writedata,
    input wire logic [3:0] avs_byteenable,
    output logic [`HB_DW-1:0] avs_readdata,
    output logic avs_waitrequest,
    output logic irq,
    input wire logic control_mode_select,
    input wire logic fault_response_select,
    input wire logic driver_enable,
    input wire logic direct_input_a,
    input wire logic direct_input_b,
    input wire logic direct_input_c,
    input wire logic direct_input_d,
    input wire logic seq_rotate_right,
    input wire logic seq_rotate_left,
    input wire logic seq_brake,
    input wire logic seq_pwm_high,
    input wire logic seq_pwm_low,
    input wire logic short_sense_a_high,
    input wire logic short_sense_b_high,
    input wire logic short_sense_a_low,
    input wire logic short_sense_b_low,
    input wire logic battery_supply_below_detect,
    input wire logic battery_supply_above_release,
    input wire logic logic_supply_low,
    input wire logic die_temp_above_upper,
    input wire logic die_temp_below_lower,
    output logic high_gate_a,
    output logic high_gate_b,
    output logic low_gate_a,
    output logic low_gate_b,
    output logic diag_flag_a,
    output logic diag_flag_b,
    output logic charge_pump_stop
);

    hb_pkg::hb_state_s st_reg;
    hb_pkg::hb_state_s st_next;

    // One half-bridge step: returns {high, low, dead time count}
    function automatic logic [`HB_CFG_W+1:0] hb_half_step(
        input logic want_h,
        input logic want_l,
        input logic on_h,
        input logic on_l,
        input logic [`HB_CFG_W-1:0] cnt,
        input logic [`HB_CFG_W-1:0] dt
    );
        logic [`HB_CFG_W+1:0] res;
        res = {1'b0, 1'b0, cnt};
        // Gap counter also blocks re-enabling the same switch
        if ((on_h && !want_h) || (on_l && !want_l))
        begin
            // Turn-off is immediate; the gap starts here
            res = {1'b0, 1'b0, dt};
        end
        else if (on_h || on_l)
        begin
            res = {on_h, on_l, cnt};
        end
        else if (cnt != '0)
        begin
            res = {1'b0, 1'b0, cnt - 1'b1};
        end
        else
        begin
            // Never both at once, even if asked
            res = {want_h && !want_l, want_l && !want_h, cnt};
        end
        return res;
    endfunction

    // Register read decode
    function automatic logic [`HB_DW-1:0] hb_read(
        input logic [`HB_AW-1:0] addr,
        input hb_pkg::hb_state_s s
    );
        logic [`HB_DW-1:0] d;
        d = '0;
        case (addr)
            `HB_ADDR_DEAD_TIME: d[`HB_CFG_W-1:0] = s.dt_cfg;
            `HB_ADDR_SHORT_FILTER: d[`HB_CFG_W-1:0] = s.flt_cfg;
            `HB_ADDR_STATUS: d[`HB_EV_W-1:0] = s.status;
            `HB_ADDR_MASK: d[`HB_EV_W-1:0] = s.mask;
            `HB_ADDR_STATE: d[11:0] = {s.low_b, s.low_a, s.high_b, s.high_a,
                                        2'b00, s.diag_b, s.diag_a,
                                        s.short_flag, s.over_temp, s.vdd_low,
                                        s.bat_uv};
            default: d = '0;
        endcase
        return d;
    endfunction

    logic want_ha;
    logic want_hb;
    logic want_la;
    logic want_lb;
    logic gate_kill;
    logic short_hit;
    logic [`HB_CFG_W+1:0] step_a;
    logic [`HB_CFG_W+1:0] step_b;
    logic [`HB_EV_W-1:0] ev;
    logic [`HB_EV_W-1:0] clr;

    always_comb
    begin
        st_next = st_reg;
        ev = '0;
        clr = '0;
        want_ha = 1'b0;
        want_hb = 1'b0;
        want_la = 1'b0;
        want_lb = 1'b0;

        // Logic supply chatter filter: level must hold the whole window
        if (logic_supply_low == st_reg.vdd_low)
        begin
            st_next.vdd_cnt = '0;
        end
        else if (st_reg.vdd_cnt == `HB_VDD_CNT_W'(`HB_VDD_FILT_CYC - 1))
        begin
            st_next.vdd_cnt = '0;
            st_next.vdd_low = logic_supply_low;
        end
        else
        begin
            st_next.vdd_cnt = st_reg.vdd_cnt + 1'b1;
        end

        // Hysteresis comes from two comparators; set wins if both
        if (battery_supply_below_detect)
        begin
            st_next.bat_uv = 1'b1;
        end
        else if (battery_supply_above_release)
        begin
            st_next.bat_uv = 1'b0;
        end

        if (die_temp_above_upper)
        begin
            st_next.over_temp = 1'b1;
        end
        else if (die_temp_below_lower)
        begin
            st_next.over_temp = 1'b0;
        end

        // Requested gates by control mode
        if (control_mode_select)
        begin
            if (driver_enable
                && !(direct_input_a && direct_input_c)
                && !(direct_input_b && direct_input_d))
            begin
                want_ha = direct_input_a;
                want_hb = direct_input_b;
                want_la = direct_input_c;
                want_lb = direct_input_d;
            end
        end
        else if (driver_enable)
        begin
            // Brake wins; both rotations together is treated as stop
            if (seq_brake)
            begin
                want_la = seq_pwm_low;
                want_lb = seq_pwm_low;
            end
            else if (seq_rotate_right && !seq_rotate_left)
            begin
                want_ha = seq_pwm_high;
                want_lb = 1'b1;
            end
            else if (seq_rotate_left && !seq_rotate_right)
            begin
                want_hb = seq_pwm_high;
                want_la = 1'b1;
            end
        end

        // Over temperature deliberately absent from the kill term
        gate_kill = !fault_response_select
            && (st_reg.bat_uv || st_reg.short_flag);
        // Kill acts on registered flags, one edge after the fault is seen
        if (gate_kill)
        begin
            want_ha = 1'b0;
            want_hb = 1'b0;
            want_la = 1'b0;
            want_lb = 1'b0;
        end

        // Both half-bridges share one dead time setting
        step_a = hb_half_step(want_ha, want_la, st_reg.high_a, st_reg.low_a,
                              st_reg.dt_cnt_a, st_reg.dt_cfg);
        step_b = hb_half_step(want_hb, want_lb, st_reg.high_b, st_reg.low_b,
                              st_reg.dt_cnt_b, st_reg.dt_cfg);
        st_next.high_a = step_a[`HB_CFG_W+1];
        st_next.low_a = step_a[`HB_CFG_W];
        st_next.dt_cnt_a = step_a[`HB_CFG_W-1:0];
        st_next.high_b = step_b[`HB_CFG_W+1];
        st_next.low_b = step_b[`HB_CFG_W];
        st_next.dt_cnt_b = step_b[`HB_CFG_W-1:0];

        // Short qualified by the gate that should hold the node
        short_hit = (short_sense_a_high && st_reg.low_a)
            || (short_sense_b_high && st_reg.low_b)
            || (short_sense_a_low && st_reg.high_a)
            || (short_sense_b_low && st_reg.high_b);
        // Count stops at the setting, so it cannot wrap while a short holds
        if (!short_hit)
        begin
            st_next.short_cnt = '0;
            st_next.short_flag = 1'b0;
        end
        else if (st_reg.short_cnt >= st_reg.flt_cfg)
        begin
            st_next.short_flag = 1'b1;
        end
        else
        begin
            st_next.short_cnt = st_reg.short_cnt + 1'b1;
        end

        // Internal reset while logic supply is low; bus registers survive
        if (st_reg.vdd_low)
        begin
            st_next.high_a = 1'b0;
            st_next.high_b = 1'b0;
            st_next.low_a = 1'b0;
            st_next.low_b = 1'b0;
            st_next.dt_cnt_a = '0;
            st_next.dt_cnt_b = '0;
            st_next.short_cnt = '0;
            st_next.short_flag = 1'b0;
        end
        st_next.cp_stop = st_next.vdd_low;

        // Diagnosis encoding in priority order
        if (st_next.bat_uv || st_next.vdd_low)
        begin
            st_next.diag_a = 1'b0;
            st_next.diag_b = 1'b0;
        end
        else if (st_next.over_temp)
        begin
            st_next.diag_a = 1'b1;
            st_next.diag_b = 1'b1;
        end
        else if (st_next.short_flag)
        begin
            st_next.diag_a = 1'b0;
            st_next.diag_b = 1'b1;
        end
        else
        begin
            st_next.diag_a = 1'b1;
            st_next.diag_b = 1'b0;
        end

        ev[`HB_EV_BAT_UV] = st_next.bat_uv && !st_reg.bat_uv;
        ev[`HB_EV_VDD_UV] = st_next.vdd_low && !st_reg.vdd_low;
        ev[`HB_EV_OVER_TEMP] = st_next.over_temp && !st_reg.over_temp;
        ev[`HB_EV_SHORT] = st_next.short_flag && !st_reg.short_flag;

        // Avalon slave: one wait cycle, answer in the second
        case (st_reg.bus)
            hb_pkg::BUS_IDLE:
            begin
                st_next.waitreq = 1'b1;
                if (avs_read || avs_write)
                begin
                    st_next.rdata = avs_read ? hb_read(avs_address, st_reg) : '0;
                    st_next.waitreq = 1'b0;
                    st_next.bus = hb_pkg::BUS_ANSWER;
                end
            end
            hb_pkg::BUS_ANSWER:
            begin
                // Write lands on the edge where waitrequest is seen low
                // Only lane 0 carries data; the other lanes are ignored
                if (avs_write && avs_byteenable[0])
                begin
                    case (avs_address)
                        `HB_ADDR_DEAD_TIME:
                            st_next.dt_cfg = avs_writedata[`HB_CFG_W-1:0];
                        `HB_ADDR_SHORT_FILTER:
                            st_next.flt_cfg = avs_writedata[`HB_CFG_W-1:0];
                        `HB_ADDR_STATUS:
                            clr = avs_writedata[`HB_EV_W-1:0];
                        `HB_ADDR_MASK:
                            st_next.mask = avs_writedata[`HB_EV_W-1:0];
                        default:
                            clr = '0;
                    endcase
                end
                st_next.waitreq = 1'b1;
                st_next.bus = hb_pkg::BUS_IDLE;
            end
            default:
            begin
                st_next.waitreq = 1'b1;
                st_next.bus = hb_pkg::BUS_IDLE;
            end
        endcase

        // A new event beats a clear in the same cycle
        st_next.status = (st_reg.status & ~clr) | ev;
        st_next.irq = |(st_next.status & st_next.mask);

        if (!rst_n)
        begin
            st_next = '0;
            st_next.bus = hb_pkg::BUS_IDLE;
            st_next.waitreq = 1'b1;
            st_next.dt_cfg = `HB_DT_RESET;
            st_next.flt_cfg = `HB_FLT_RESET;
            st_next.status = `HB_STATUS_RESET;
            st_next.mask = `HB_MASK_RESET;
            st_next.diag_a = 1'b1;
        end
    end

    always_ff @(posedge core_clk)
    begin
        st_reg <= st_next;
    end

    assign avs_readdata = st_reg.rdata;
    assign avs_waitrequest = st_reg.waitreq;
    assign irq = st_reg.irq;
    assign high_gate_a = st_reg.high_a;
    assign high_gate_b = st_reg.high_b;
    assign low_gate_a = st_reg.low_a;
    assign low_gate_b = st_reg.low_b;
    assign diag_flag_a = st_reg.diag_a;
    assign diag_flag_b = st_reg.diag_b;
    assign charge_pump_stop = st_reg.cp_stop;

endmodule

`default_nettype wire

/* hb_gate_ctrl_properties.sv */
// Port-level concurrent checks of the gate control block
`timescale 1ns/1ps
`default_nettype none
`include "hb_params.svh"
module hb_gate_ctrl_checker (
    input wire logic core_clk,
    input wire logic rst_n,
    input wire logic [`HB_AW-1:0] avs_address,
    input wire logic avs_write,
    input wire logic [`HB_DW-1:0] avs_writedata,
    input wire logic [3:0] avs_byteenable,
    input wire logic avs_waitrequest,
    input wire logic control_mode_select,
    input wire logic fault_response_select,
    input wire logic driver_enable,
    input wire logic direct_input_a,
    input wire logic direct_input_c,
    input wire logic battery_supply_below_detect,
    input wire logic battery_supply_above_release,
    input wire logic logic_supply_low,
    input wire logic die_temp_above_upper,
    input wire logic high_gate_a,
    input wire logic high_gate_b,
    input wire logic low_gate_a,
    input wire logic low_gate_b,
    input wire logic diag_flag_a,
    input wire logic diag_flag_b,
    input wire logic charge_pump_stop
);
    // Dead time is not a port, so it is tracked from accepted bus writes
    logic [`HB_CFG_W-1:0] dt_reg;
    logic [8:0] off_reg;
    wire logic all_off = !(high_gate_a || high_gate_b || low_gate_a || low_gate_b);
    default clocking @(posedge core_clk); endclocking
    default disable iff (!rst_n);
    always_ff @(posedge core_clk)
    begin
        if (!rst_n)
        begin
            dt_reg <= `HB_DT_RESET;
            off_reg <= 9'h1ff;
        end
        else
        begin
            if (avs_write && !avs_waitrequest && avs_address == `HB_ADDR_DEAD_TIME
                && avs_byteenable[0])
                dt_reg <= avs_writedata[7:0];
            off_reg <= (high_gate_a || low_gate_a) ? 9'h000 :
                off_reg + {8'h00, off_reg != 9'h1ff};
        end
    end
    enable_off_a: assert property (!driver_enable |=> all_off)
        else $error("gate on after enable low");
    no_shoot_a:
        assert property (!(high_gate_a && low_gate_a) && !(high_gate_b && low_gate_b))
        else $error("both switches of a half-bridge on");
    cross_cond_a:
        assert property (control_mode_select && direct_input_a && direct_input_c |=> all_off)
        else $error("conflicting direct inputs not refused");
    dead_gap_a:
        assert property ($rose(high_gate_a) || $rose(low_gate_a) |-> off_reg > {1'b0, dt_reg})
        else $error("half-bridge turned on inside dead time");
    diag_uv_a:
        assert property (battery_supply_below_detect |=> !diag_flag_a && !diag_flag_b)
        else $error("undervoltage code missing");
    over_temp_a:
        assert property (die_temp_above_upper && !battery_supply_below_detect
            && battery_supply_above_release && !logic_supply_low && !charge_pump_stop
            |=> diag_flag_a && diag_flag_b)
        else $error("overtemperature code missing");
    uv_force_a:
        assert property (!fault_response_select && battery_supply_below_detect
            ##1 !fault_response_select && !battery_supply_above_release |=> all_off)
        else $error("gates not forced off in undervoltage");
    vdd_hold_a:
        assert property (charge_pump_stop && $past(charge_pump_stop)
            |-> all_off && !diag_flag_a && !diag_flag_b)
        else $error("logic supply low without gates off");
endmodule
bind hb_gate_ctrl hb_gate_ctrl_checker i_checker (.*);
`default_nettype wire

/* hb_gate_ctrl_tb.sv */
// Self-checking bench of the gate control block
`timescale 1ns/1ps
`default_nettype none
`include "hb_params.svh"
module hb_gate_ctrl_tb;
    logic core_clk = 1'b0;
    logic rst_n = 1'b0;
    logic [`HB_AW-1:0] avs_address = 5'h00;
    logic avs_read = 1'b0;
    logic avs_write = 1'b0;
    logic [`HB_DW-1:0] avs_writedata = 32'h0;
    logic [3:0] avs_byteenable = 4'hf;
    logic [`HB_DW-1:0] avs_readdata;
    logic avs_waitrequest, irq, charge_pump_stop;
    logic control_mode_select, fault_response_select, driver_enable;
    logic direct_input_a, direct_input_b, direct_input_c, direct_input_d;
    logic seq_rotate_right, seq_rotate_left, seq_brake, seq_pwm_high, seq_pwm_low;
    logic short_sense_a_high, short_sense_b_high, short_sense_a_low, short_sense_b_low;
    logic battery_supply_below_detect = 1'b0;
    logic battery_supply_above_release = 1'b1;
    logic logic_supply_low = 1'b0;
    logic die_temp_above_upper = 1'b0;
    logic die_temp_below_lower = 1'b1;
    logic high_gate_a, high_gate_b, low_gate_a, low_gate_b, diag_flag_a, diag_flag_b;
    logic [11:0] pins;
    logic [11:0] want = 12'h000;
    logic [3:0] sense = 4'h0;
    logic [31:0] rd;
    int fail_count = 0;
    int num_checks = 0;
    int cyc = 0;
    int n;
    assign {control_mode_select, fault_response_select, driver_enable, direct_input_a,
        direct_input_b, direct_input_c, direct_input_d, seq_rotate_right, seq_rotate_left,
        seq_brake, seq_pwm_high, seq_pwm_low} = pins;
    assign {short_sense_a_low, short_sense_b_low, short_sense_a_high, short_sense_b_high} = sense;
    wire logic [3:0] gates = {high_gate_a, high_gate_b, low_gate_a, low_gate_b};
    wire logic [1:0] diag = {diag_flag_a, diag_flag_b};
    hb_mcu_model i_mcu (.core_clk(core_clk), .want(want), .pins(pins));
    hb_gate_ctrl i_dut (.*);
    always #25 core_clk = ~core_clk;
    task automatic tick(input int k);
        repeat (k) @(posedge core_clk);
    endtask
    task automatic check(input string nm, input logic [31:0] seen, input logic [31:0] exp);
        num_checks++;
        if (seen !== exp)
        begin
            fail_count++;
            $display("[FAIL] %s expected %h seen %h", nm, exp, seen);
        end
    endtask
    // Held until waitrequest is seen low; the extra edge keeps strobes from retriggering
    task automatic bus(input logic wr, input logic [4:0] a, input logic [31:0] d);
        avs_address <= a;
        avs_writedata <= d;
        avs_write <= wr;
        avs_read <= !wr;
        do @(posedge core_clk); while (avs_waitrequest !== 1'b0);
        rd = avs_readdata;
        avs_write <= 1'b0;
        avs_read <= 1'b0;
        @(posedge core_clk);
    endtask
    task automatic rchk(input string nm, input logic [4:0] a, input logic [31:0] e);
        bus(1'b0, a, 32'h0);
        check(nm, rd, e);
    endtask
    task automatic close_out;
        $display("Checks %0d mismatches %0d", num_checks, fail_count);
        if (fail_count == 0 && num_checks > 0)
            $display("Regression OK");
        else
            $display("Regression broken");
        $finish;
    endtask
    always @(posedge core_clk)
    begin
        cyc++;
        if (cyc == 20000)
        begin
            fail_count++;
            close_out();
        end
    end
    initial
    begin
        tick(8);
        rst_n <= 1'b1;
        tick(2);
        rchk("dead_time", `HB_ADDR_DEAD_TIME, 32'h0000000a);
        rchk("short_filter", `HB_ADDR_SHORT_FILTER, 32'h00000004);
        avs_byteenable <= 4'he;
        bus(1'b1, `HB_ADDR_SHORT_FILTER, 32'h00000009);
        avs_byteenable <= 4'hf;
        rchk("filter_lane_off", `HB_ADDR_SHORT_FILTER, 32'h00000004);
        bus(1'b1, 5'h14, 32'h0000005a);
        rchk("unmapped", 5'h14, 32'h0);
        bus(1'b1, `HB_ADDR_SHORT_FILTER, 32'h00000003);
        bus(1'b1, `HB_ADDR_DEAD_TIME, 32'hffffff02);
        for (int i = 0; i < 16; i++)
        begin
            want <= {3'b101, 4'(i), 5'h00};
            tick(10);
            check("direct", gates, (i[3] & i[1] | i[2] & i[0]) ? 4'h0 : 4'(i));
        end
        want <= {3'b100, 4'h9, 5'h00};
        tick(6);
        check("enable_low", gates, 4'h0);
        want <= {3'b001, 4'h0, 5'b10010};
        tick(10);
        check("seq_right", gates, 4'h9);
        want <= {3'b001, 4'h0, 5'b01010};
        tick(10);
        check("seq_left", gates, 4'h6);
        want <= {3'b001, 4'hf, 5'b00101};
        tick(10);
        check("seq_brake", gates, 4'h3);
        // Dead time at its smallest and at a nonzero setting
        for (int k = 0; k < 3; k += 2)
        begin
            bus(1'b1, `HB_ADDR_DEAD_TIME, k);
            want <= {3'b101, 4'h8, 5'h00};
            tick(10);
            want <= {3'b101, 4'h2, 5'h00};
            do @(posedge core_clk); while (high_gate_a !== 1'b0);
            n = 0;
            while (low_gate_a !== 1'b1)
            begin
                n++;
                @(posedge core_clk);
            end
            check("dead_cycles", n, k + 1);
        end
        want <= {3'b101, 4'h8, 5'h00};
        tick(10);
        check("diag_normal", diag, 2'b10);
        rchk("state_normal", `HB_ADDR_STATE, 32'h00000110);
        die_temp_above_upper <= 1'b1;
        die_temp_below_lower <= 1'b0;
        tick(1);
        die_temp_above_upper <= 1'b0;
        tick(4);
        check("diag_hot", diag, 2'b11);
        check("hot_gates", gates, 4'h8);
        battery_supply_below_detect <= 1'b1;
        battery_supply_above_release <= 1'b0;
        tick(1);
        battery_supply_below_detect <= 1'b0;
        tick(4);
        check("diag_uv_hot", diag, 2'b00);
        check("uv_gates_off", gates, 4'h0);
        want <= {3'b111, 4'h8, 5'h00};
        tick(8);
        check("uv_gates_kept", gates, 4'h8);
        battery_supply_above_release <= 1'b1;
        tick(4);
        check("diag_hot_again", diag, 2'b11);
        die_temp_below_lower <= 1'b1;
        tick(4);
        check("diag_cool", diag, 2'b10);
        bus(1'b1, `HB_ADDR_STATUS, 32'h0000000f);
        bus(1'b1, `HB_ADDR_MASK, 32'h00000004);
        check("irq_idle", irq, 1'b0);
        die_temp_above_upper <= 1'b1;
        die_temp_below_lower <= 1'b0;
        tick(1);
        die_temp_above_upper <= 1'b0;
        die_temp_below_lower <= 1'b1;
        tick(4);
        check("irq_hot", irq, 1'b1);
        rchk("status_hot", `HB_ADDR_STATUS, 32'h00000004);
        bus(1'b1, `HB_ADDR_MASK, 32'h0);
        tick(1);
        check("irq_masked", irq, 1'b0);
        bus(1'b1, `HB_ADDR_MASK, 32'h00000004);
        bus(1'b1, `HB_ADDR_STATUS, 32'h00000004);
        tick(1);
        check("irq_cleared", irq, 1'b0);
        for (int i = 0; i < 4; i++)
        begin
            want <= {3'b111, 4'h8 >> i, 5'h00};
            tick(10);
            sense <= 4'h8 >> ((i + 1) % 4);
            tick(10);
            check("short_unqualified", diag, 2'b10);
            sense <= 4'h8 >> i;
            tick(3);
            sense <= 4'h0;
            n = 0;
            repeat (6)
            begin
                @(posedge core_clk);
                n += (diag === 2'b01);
            end
            check("short_too_brief", n, 0);
            sense <= 4'h8 >> i;
            tick(10);
            check("diag_short", diag, 2'b01);
            check("short_gates_kept", gates, 4'h8 >> i);
            die_temp_above_upper <= 1'b1;
            die_temp_below_lower <= 1'b0;
            tick(3);
            check("diag_hot_short", diag, 2'b11);
            die_temp_above_upper <= 1'b0;
            die_temp_below_lower <= 1'b1;
            sense <= 4'h0;
            tick(4);
        end
        // A held short with gates forced off recovers and trips again
        want <= {3'b101, 4'h8, 5'h00};
        tick(10);
        sense <= 4'h8;
        n = 0;
        repeat (40)
        begin
            @(posedge core_clk);
            n += (gates === 4'h0);
        end
        check("short_forces_off", n != 0, 1'b1);
        sense <= 4'h0;
        want <= {3'b111, 4'h8, 5'h00};
        tick(10);
        logic_supply_low <= 1'b1;
        tick(20);
        logic_supply_low <= 1'b0;
        tick(4);
        check("vdd_glitch", {charge_pump_stop, gates}, 5'h08);
        logic_supply_low <= 1'b1;
        tick(50);
        check("vdd_reset", {charge_pump_stop, diag, gates}, 7'h40);
        logic_supply_low <= 1'b0;
        tick(50);
        check("vdd_release", {charge_pump_stop, diag, gates}, 7'h28);
        close_out();
    end
endmodule
`default_nettype wire

/* hb_mcu_model.sv */
// Controller stand-in that drives the control pins
`timescale 1ns/1ps
`default_nettype none
module hb_mcu_model (
    input wire logic core_clk,
    input wire logic [11:0] want,
    output logic [11:0] pins
);
    // Pins move only after an edge, like a clocked port of the controller
    initial pins = 12'h000;
    always @(posedge core_clk)
        pins <= want;
endmodule
`default_nettype wire

/* hb_params.svh */
// Constants of the H-bridge gate control and fault diagnosis block
`ifndef HB_PARAMS_SVH
`define HB_PARAMS_SVH

`define HB_AW 5
`define HB_DW 32
`define HB_ADDR_DEAD_TIME 5'h00
`define HB_ADDR_SHORT_FILTER 5'h04
`define HB_ADDR_STATUS 5'h08
`define HB_ADDR_MASK 5'h0c
`define HB_ADDR_STATE 5'h10

`define HB_CFG_W 8
`define HB_EV_W 4
`define HB_EV_BAT_UV 0
`define HB_EV_VDD_UV 1
`define HB_EV_OVER_TEMP 2
`define HB_EV_SHORT 3

`define HB_DT_RESET 8'h0a
`define HB_FLT_RESET 8'h04
`define HB_MASK_RESET 4'h0
`define HB_STATUS_RESET 4'h0

`define HB_CLK_NS 50
`define HB_VDD_FILT_NS 2000
`define HB_VDD_FILT_CYC ((`HB_VDD_FILT_NS + `HB_CLK_NS - 1) / `HB_CLK_NS)
`define HB_VDD_CNT_W 6

`endif

/* hb_pkg.sv */
// Types of the H-bridge gate control and fault diagnosis block
`include "hb_params.svh"

package hb_pkg;

    typedef enum logic {
        BUS_IDLE,
        BUS_ANSWER
    } hb_bus_e;

    typedef struct packed {
        hb_bus_e bus;
        logic waitreq;
        logic [`HB_DW-1:0] rdata;
        logic [`HB_CFG_W-1:0] dt_cfg;
        logic [`HB_CFG_W-1:0] flt_cfg;
        logic [`HB_EV_W-1:0] status;
        logic [`HB_EV_W-1:0] mask;
        logic irq;
        logic high_a;
        logic high_b;
        logic low_a;
        logic low_b;
        logic [`HB_CFG_W-1:0] dt_cnt_a;
        logic [`HB_CFG_W-1:0] dt_cnt_b;
        logic [`HB_CFG_W-1:0] short_cnt;
        logic short_flag;
        logic bat_uv;
        logic over_temp;
        logic [`HB_VDD_CNT_W-1:0] vdd_cnt;
        logic vdd_low;
        logic diag_a;
        logic diag_b;
        logic cp_stop;
    } hb_state_s;

endpackage
